// ---- ptt_defines.vh ----
// register offsets, field positions, reset values for the periodic tick timer
`ifndef PTT_DEFINES_VH
`define PTT_DEFINES_VH
`define PTT_OFF_CTRL 4'h0
`define PTT_OFF_PERIOD 4'h4
`define PTT_OFF_CURRENT 4'h8
`define PTT_OFF_STATUS 4'hC
`define PTT_OFF_MASK 5'h10
`define PTT_CTRL_EN 0
`define PTT_CTRL_INTEN 1
`define PTT_PERIOD_RST 25'h1000000
`define PTT_CNT_W 24
`define PTT_PER_W 25
`endif

// ---- ptt_timer.v ----
// periodic tick timer with an AHB-Lite register slave
// Operation
// - disabled timer stops, holds its count, raises no wrap events
// - enabling resumes from the held count without reload
// - any write to current count clears it; reload follows next clock
// - if disabled at that write, reload happens first clock after enable
// - each rollover of the running counter produces a wrap event
// - interrupt enable and mask bit together gate the wrap event onto the interrupt
// - pending interrupt clears automatically on handler entry
// - writing period does not disturb count; used at next reload
// - reading period returns programmed wrap interval in clocks
// - after a reload, current count reads between zero and period minus one
`timescale 1ns/1ps
`default_nettype none
`include "ptt_defines.vh"
module ptt_timer (
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire handler_entry,
    output reg irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg en_q;
    reg inten_q;
    reg [`PTT_PER_W-1:0] period_q;
    reg [`PTT_CNT_W-1:0] count_q;
    reg reload_pend_q;
    reg status_q;
    reg mask_q;
    reg dp_wr_q;
    reg [4:0] dp_addr_q;
    wire addr_ok;
    wire addr_hi_ok;
    wire take;
    wire wr_ctrl;
    wire wr_period;
    wire wr_current;
    wire wr_status;
    wire wr_mask;
    wire wrap;
    wire [`PTT_CNT_W-1:0] reload_val;
    wire irq_d;
    reg [31:0] rdata_d;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign take = hsel & hready & htrans[1];
    assign addr_ok = (haddr[1:0] == 2'h0);
    // upper address bits must be zero, so 0x20 and above do not alias the map
    assign addr_hi_ok = (haddr[31:5] == 27'h0000000);
    assign wr_ctrl = dp_wr_q & (dp_addr_q == {1'b0, `PTT_OFF_CTRL});
    assign wr_period = dp_wr_q & (dp_addr_q == {1'b0, `PTT_OFF_PERIOD});
    assign wr_current = dp_wr_q & (dp_addr_q == {1'b0, `PTT_OFF_CURRENT});
    assign wr_status = dp_wr_q & (dp_addr_q == {1'b0, `PTT_OFF_STATUS});
    assign wr_mask = dp_wr_q & (dp_addr_q == `PTT_OFF_MASK);

    // address phase captured; slave answers with zero wait states
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= 5'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            dp_wr_q <= take & hwrite & addr_ok & addr_hi_ok;
            dp_addr_q <= haddr[4:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // a period of 2^24 reloads as 0xFFFFFF, which counts the full 2^24 clocks
    assign reload_val = period_q[`PTT_CNT_W-1:0] - 24'h000001;
    assign wrap = en_q & ~reload_pend_q & (count_q == 24'h000000);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q <= 1'b0;
            inten_q <= 1'b0;
            period_q <= `PTT_PERIOD_RST;
            count_q <= 24'h000000;
            reload_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                en_q <= hwdata[`PTT_CTRL_EN];
                inten_q <= hwdata[`PTT_CTRL_INTEN];
            end
            // new period waits for next reload
            if (wr_period) begin
                period_q <= hwdata[`PTT_PER_W-1:0];
            end
            if (wr_current) begin
                count_q <= 24'h000000;
                reload_pend_q <= 1'b1;
            end else if (en_q) begin
                if (reload_pend_q || count_q == 24'h000000) begin
                    count_q <= reload_val;
                    reload_pend_q <= 1'b0;
                end else begin
                    count_q <= count_q - 24'h000001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt: sticky status, set wins over clear
    // ----------------------------------------------------------------
    assign irq_d = status_q & mask_q & inten_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= 1'b0;
            mask_q <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            if (wrap) begin
                status_q <= 1'b1;
            end else if (handler_entry || (wr_status && hwdata[0])) begin
                status_q <= 1'b0;
            end
            if (wr_mask) begin
                mask_q <= hwdata[0];
            end
            irq <= irq_d & ~handler_entry;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always @* begin
        rdata_d = 32'h00000000;
        case (haddr[4:0])
            {1'b0, `PTT_OFF_CTRL}: rdata_d = {30'h0, inten_q, en_q};
            {1'b0, `PTT_OFF_PERIOD}: rdata_d = {7'h00, period_q};
            {1'b0, `PTT_OFF_CURRENT}: rdata_d = {8'h00, count_q};
            {1'b0, `PTT_OFF_STATUS}: rdata_d = {31'h0, status_q};
            `PTT_OFF_MASK: rdata_d = {31'h0, mask_q};
            default: rdata_d = 32'h00000000;
        endcase
        if (!addr_hi_ok) begin
            rdata_d = 32'h00000000;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (clk_en && take && !hwrite) begin
            hrdata <= rdata_d;
        end
    end
endmodule
`default_nettype wire

// ---- ptt_asserts.sv ----
// port assertions for the periodic tick timer
`timescale 1ns/1ps
`default_nettype none
module ptt_asserts (input wire hclk, hresetn, clk_en, hsel, hwrite, hready, handler_entry,
    input wire [31:0] haddr, hwdata, input wire [1:0] htrans, input wire [2:0] hsize,
    input wire hreadyout, hresp, irq, input wire [31:0] hrdata);
    // a read taken on this edge
    wire rd_tk = hsel && hready && htrans[1] && !hwrite && clk_en;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_rdy; hreadyout; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state seen");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_hold; !rd_tk |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_frz; !clk_en |=> $stable(irq) && $stable(hrdata); endproperty
    a_frz: assert property (p_frz) else $error("state moved while frozen");
    // a fall needs handler entry or a register write two or three edges back
    property p_fell; $fell(irq) |-> $past(handler_entry)
        || $past(hsel && htrans[1] && hwrite, 2) || $past(hsel && htrans[1] && hwrite, 3);
    endproperty
    a_fell: assert property (p_fell) else $error("irq fell without cause");
    property p_rose; $rose(irq) |-> $past(clk_en); endproperty
    a_rose: assert property (p_rose) else $error("irq rose while frozen");
    property p_unm; rd_tk && haddr == 32'h20 |=> hrdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_per; rd_tk && haddr == 32'h4 |=> hrdata[31:25] == 7'h0; endproperty
    a_per: assert property (p_per) else $error("period out of range");
endmodule
bind ptt_timer ptt_asserts chk (.*);
`default_nettype wire

// ---- ptt_timer_tb.sv ----
// self-checking bench for the periodic tick timer
`timescale 1ns/1ps
`default_nettype none
module ptt_timer_tb;
    logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0, handler_entry = 0;
    logic [31:0] haddr = 0, hwdata = 0, rv, p;
    logic [1:0] htrans = 0;
    logic [31:0] q[$];
    wire hreadyout, hresp, irq;
    wire [31:0] hrdata;
    int mismatches = 0, comparisons = 0;
    event got;
    ptt_timer dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .handler_entry(handler_entry), .irq(irq));
    initial forever #10 hclk = ~hclk;
    task check(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task test_done;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // single word transfer, address phase then data phase
    task bus(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
        do @(posedge hclk); while (!hreadyout);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
        rv = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
        if (!w && q.size() > 0) ->got;
    endtask
    task rd(input logic [31:0] a, e);
        q.push_back(e);
        bus(0, a, 32'h0);
    endtask
    // monitor: oldest note against each read result from rd
    initial forever begin
        @got;
        check("rdata", rv, q.pop_front());
    end
    initial begin
        #100us mismatches++;
        test_done;
    end
    initial begin
        void'($urandom(32'hA015D91F));
        p = 32'h4 + $urandom % 12;
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        rd(32'h0, 32'h0);
        rd(32'h4, 32'h1000000);
        rd(32'h8, 32'h0);
        bus(1, 32'h4, p);
        rd(32'h4, p);
        bus(1, 32'h8, $urandom);
        rd(32'h8, 32'h0);
        bus(1, 32'h10, 32'h1);
        bus(1, 32'h0, 32'h1);
        rd(32'h20, 32'h0);
        bus(0, 32'h8, 32'h0);
        check("count range", {31'h0, rv < p}, 32'h1);
        repeat (40) @(posedge hclk);
        check("irq", irq, 32'h0);
        rd(32'hC, 32'h1);
        bus(1, 32'h0, 32'h3);
        repeat (50) if (!irq) @(posedge hclk);
        check("irq", irq, 32'h1);
        // stop counting first so no wrap races the handler
        bus(1, 32'h0, 32'h2);
        clk_en <= 0;
        repeat (3) @(posedge hclk);
        clk_en <= 1;
        handler_entry <= 1;
        @(posedge hclk);
        handler_entry <= 0;
        repeat (3 * p) @(posedge hclk);
        check("irq", irq, 32'h0);
        test_done;
    end
endmodule
`default_nettype wire
